// file: bench/tb.sv
// Purpose: Self-checking bench joining controller and processor ends.
// Assumes: 20 MHz clock, clock enable held high, default memory window.
// Notes: A bench copy of the snoop filter predicts which cycles snoop.
`timescale 1ns/1ps
module tb;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic [vma_pkg::NUM_VL-1:0] lreq_in = '0;
  logic [vma_pkg::NUM_VL-1:0] lgnt_out;
  logic lads_in = 1'b0;
  logic lbw_r_in = 1'b0;
  logic blast_in = 1'b1;
  logic [31:0] lbadr_in = '0;
  logic [31:0] mem_base_in = vma_pkg::MEM_BASE_RST;
  logic [31:0] mem_limit_in = vma_pkg::MEM_LIMIT_RST;
  logic lrdy_out, brdy_out, lbdata_oe_n_out, wq_valid_out, rq_valid_out;
  logic isa_start_out, invalidate_out, snoop_seen_out;
  logic [31:0] lbdata_out;
  logic [63:0] wq_data_out, rq_data_out;
  logic tag_busy_in = 1'b0;
  logic line_modified_in = 1'b0;
  logic snoop_is_write_in = 1'b0;
  logic req_in = 1'b0;
  logic [63:0] wb_data_in = '0;
  logic [31:5] filt [4];
  int wp = 0;
  int bad_count = 0;
  int num_checks = 0;
  vma_bus_if bus_if ();
  vma_ctrl_end vma_ctrl_end_inst (.sys_clk_in, .resetn_in, .clk_en_in,
    .bus(bus_if), .lreq_in, .lgnt_out, .lads_in, .lbw_r_in, .blast_in,
    .lbadr_in, .lrdy_out, .brdy_out, .lbdata_out, .lbdata_oe_n_out,
    .wq_data_out, .wq_valid_out, .rq_data_out, .rq_valid_out,
    .isa_start_out, .mem_base_in, .mem_limit_in);
  vma_cpu_end vma_cpu_end_inst (.sys_clk_in, .resetn_in, .clk_en_in,
    .bus(bus_if), .tag_busy_in, .line_modified_in, .snoop_is_write_in,
    .wb_data_in, .req_in, .invalidate_out, .snoop_seen_out);
  vma_asserts vma_asserts_inst (.sys_clk_in, .resetn_in,
    .grant(bus_if.grant),
    .ctrl_address_latch_out(bus_if.ctrl_address_latch_out),
    .ctrl_transfer_ack(bus_if.ctrl_transfer_ack),
    .ctrl_transfer_hold(bus_if.ctrl_transfer_hold),
    .cpu_transfer_ack(bus_if.cpu_transfer_ack),
    .cpu_addr_latch_req(bus_if.cpu_addr_latch_req),
    .cpu_normal_request(bus_if.cpu_normal_request),
    .ctrl_ad_oe_n(bus_if.ctrl_ad_oe_n), .lreq_in, .lgnt_out, .lads_in,
    .lrdy_out, .brdy_out);
  always #25 sys_clk_in = ~sys_clk_in;
  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [63:0] seen,
                     input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick;
    @(posedge sys_clk_in);
    #5;
  endtask : tick
  function automatic logic filt_hit(input logic [31:0] a);
    return a[31:5] == filt[0] || a[31:5] == filt[1] ||
           a[31:5] == filt[2] || a[31:5] == filt[3];
  endfunction : filt_hit
  // -------------------------------------------------------------------
  // One VL-master cycle, from request to restored processor grant
  // -------------------------------------------------------------------
  // The bench master caches nothing, so it is write-through.
  task automatic vl_cycle(input int idx, input logic [31:0] addr,
                          input logic wr, dirty, busy, early);
    int n, ale_at, rdy_at, beats, ack_at, lat_at;
    logic mem, hit, inv, isa, gp, fin, seen, burst;
    logic [63:0] wb;
    mem = addr <= mem_limit_in;
    hit = mem && filt_hit(addr);
    wb = {$urandom, $urandom};
    lreq_in[idx] = 1'b1;
    lbadr_in = addr;
    lbw_r_in = wr;
    snoop_is_write_in = wr;
    line_modified_in = dirty;
    tag_busy_in = busy;
    wb_data_in = wb;
    burst = ($urandom % 3) == 0;
    blast_in = !burst;
    n = 0;
    gp = 1'b1;
    while (lgnt_out[idx] !== 1'b1 && n < 10)
    begin
      gp = bus_if.grant;
      tick();
      n++;
    end
    chk("lgnt", lgnt_out[idx], 1);
    chk("grant_before_lgnt", gp, 0);
    req_in = 1'($urandom % 2);
    lads_in = 1'b1;
    tick();
    lads_in = 1'b0;
    if (early)
      lreq_in[idx] = 1'b0;
    {ale_at, rdy_at, beats, ack_at, lat_at, inv, isa, seen} = '0;
    for (int k = 1; k <= 40 && rdy_at == 0; k++)
    begin
      if (bus_if.ctrl_address_latch_out === 1'b1 &&
          bus_if.ctrl_ad_oe_n === 1'b0 && ale_at == 0)
      begin
        ale_at = k;
        chk("snoop_addr", bus_if.ad[31:5], addr[31:5]);
      end
      if (wq_valid_out === 1'b1)
      begin
        beats++;
        chk("wq_data", wq_data_out, wb);
        chk("rq_valid", rq_valid_out, !wr);
        chk("lb_oe_n", lbdata_oe_n_out, wr);
        if (!wr)
        begin
          chk("rq_data", rq_data_out, wb);
          chk("lb_data", lbdata_out, wb[31:0]);
        end
      end
      if (bus_if.ctrl_transfer_ack === 1'b1 && ack_at == 0)
        ack_at = k;
      if (bus_if.cpu_addr_latch_req === 1'b1)
        lat_at = k;
      inv |= invalidate_out === 1'b1;
      seen |= snoop_seen_out === 1'b1;
      isa |= isa_start_out === 1'b1;
      if (lrdy_out === 1'b1 || brdy_out === 1'b1)
        rdy_at = k;
      else
        tick();
    end
    if (!mem)
    begin
      chk("isa_start", isa, 1);
      chk("isa_no_snoop", ale_at, 0);
    end
    else if (hit)
    begin
      chk("filter_skip", ale_at, 0);
      chk("rdy_hit", rdy_at, 2);
    end
    else
    begin
      chk("snoop_at", ale_at, 2);
      chk("rdy_after_snoop", rdy_at > ale_at, 1);
      if (!dirty)
        chk("rdy_miss", rdy_at, busy ? 5 : 4);
      chk("invalidate", inv, 1);
      if (dirty)
      begin
        chk("wb_beats", beats, 4);
        chk("wb_ale_gap", lat_at - ack_at, vma_pkg::ACK_TO_ALE_CLKS);
      end
      filt[wp] = addr[31:5];
      wp = (wp + 1) % 4;
    end
    chk("snoop_seen", seen, wr && mem && !hit);
    if (rdy_at > 0)
      chk("rdy_kind", {lrdy_out, brdy_out}, {!burst, burst});
    // A write burst runs four dwords; the last one raises the last flag.
    if (rdy_at > 0 && burst && wr)
    begin
      repeat (vma_pkg::BURST_DWORDS - 2)
      begin
        tick();
        chk("burst_brdy", brdy_out, 1);
      end
      tick();
      blast_in = 1'b1;
      #1;
      chk("burst_last", lrdy_out, 1);
    end
    fin = rdy_at > 0 && !early;
    if (fin)
      tick();
    lreq_in[idx] = 1'b0;
    tick();
    if (fin)
      chk("lgnt_drop", lgnt_out[idx], 0);
    tick();
    if (fin)
      chk("grant_back", bus_if.grant, 1);
    req_in = 1'b0;
    repeat (6) tick();
    chk("grant_idle", bus_if.grant, 1);
  endtask : vl_cycle
  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial
  begin
    logic [31:0] a;
    void'($urandom(55));
    foreach (filt[i])
      filt[i] = '1;
    repeat (12) @(posedge sys_clk_in);
    #5 resetn_in = 1'b1;
    chk("grant_rst", bus_if.grant, 1);
    chk("lgnt_rst", lgnt_out, 0);
    vl_cycle(0, 32'h0000_1000, 0, 0, 0, 0);
    vl_cycle(1, 32'h0000_1008, 1, 0, 0, 0);
    vl_cycle(2, 32'h0000_2000, 0, 1, 0, 0);
    vl_cycle(0, 32'h0000_3000, 1, 1, 0, 0);
    vl_cycle(1, 32'h0000_4000, 0, 0, 1, 0);
    vl_cycle(2, 32'h0000_1010, 0, 0, 0, 0);
    vl_cycle(0, 32'h0000_5000, 1, 0, 0, 0);
    vl_cycle(1, 32'h0000_1000, 0, 0, 0, 0);
    vl_cycle(2, 32'h0200_0000, 1, 0, 0, 0);
    vl_cycle(0, 32'h0000_6000, 0, 0, 0, 1);
    repeat (30)
    begin
      a = 32'h0000_1000 + ($urandom % 8) * 32;
      if ($urandom % 6 == 0)
        a = a | 32'h0100_0000;
      vl_cycle($urandom % 3, a, 1'($urandom), 1'($urandom),
               1'($urandom), 1'b0);
    end
    stop_test();
  end
  // Forty cycles of at most about fifty clocks each; allow three times that span.
  initial
  begin
    #(50 * 6000);
    bad_count++;
    stop_test();
  end
endmodule : tb

// file: bench/vma_asserts.sv
// Purpose: Concurrent checks on the processor bus and the VL arbitration.
// Assumes: One clock domain; the bench holds the clock enable high.
// Notes: Takes interface and port signals as plain inputs; no bind.
`timescale 1ns/1ps
module vma_asserts (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic grant,
  input wire logic ctrl_address_latch_out,
  input wire logic ctrl_transfer_ack,
  input wire logic ctrl_transfer_hold,
  input wire logic cpu_transfer_ack,
  input wire logic cpu_addr_latch_req,
  input wire logic cpu_normal_request,
  input wire logic ctrl_ad_oe_n,
  input wire logic [vma_pkg::NUM_VL-1:0] lreq_in,
  input wire logic [vma_pkg::NUM_VL-1:0] lgnt_out,
  input wire logic lads_in,
  input wire logic lrdy_out,
  input wire logic brdy_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  // -------------------------------------------------------------------
  // Sequences
  // -------------------------------------------------------------------
  sequence s_term;
    (|lgnt_out) && lreq_in == '0 && ($past(lrdy_out) || $past(brdy_out));
  endsequence
  sequence s_wb_ack;
    ctrl_transfer_ack [*4];
  endsequence
  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  // The processor may own the bus under a VL grant only for a write-back.
  a_grant_excl: assert property (
    |lgnt_out && grant |-> cpu_addr_latch_req || ctrl_transfer_ack ||
      $past(ctrl_transfer_ack))
    else $error("processor grant overlaps a VL grant");
  a_grant_first: assert property (
    $rose(|lgnt_out) |-> $past(grant) == 1'b0)
    else $error("VL grant not one clock after grant drop");
  a_grant_idle: assert property (
    (lreq_in == '0 && lgnt_out == '0) [*3] |-> grant)
    else $error("processor grant not held while idle");
  a_grant_back: assert property (
    $fell(|lgnt_out) && (cpu_normal_request || lreq_in == '0) |=> grant)
    else $error("processor grant not restored");
  a_lgnt_release: assert property (s_term |=> lgnt_out == '0)
    else $error("VL grant not dropped one clock after request");
  a_snoop_start: assert property (
    ctrl_address_latch_out && !ctrl_ad_oe_n |-> $past(lads_in, 2) && !grant)
    else $error("snoop latch not two clocks after strobe");
  a_ack_echo: assert property (
    cpu_transfer_ack && !ctrl_transfer_hold |-> ctrl_transfer_ack)
    else $error("processor acknowledge not echoed");
  a_wb_ack: assert property (
    cpu_addr_latch_req |=> s_wb_ack ##1 !ctrl_transfer_ack)
    else $error("write-back acknowledge not four clocks");
  a_wb_latch: assert property (
    cpu_addr_latch_req |-> ctrl_address_latch_out && grant)
    else $error("hit address latch not answered with grant");
  a_rdy_gap: assert property (
    lads_in && |lgnt_out |-> (!lrdy_out && !brdy_out) [*2])
    else $error("ready too soon after strobe");
endmodule : vma_asserts

// file: hw/vma_bus_if.sv
// Purpose: Processor-bus carrier between the controller and the processor.
// Assumes: Both ends clocked by sys_clk_in.
// Notes: The address/data bus is resolved here from the two output enables.
`timescale 1ns/1ps
interface vma_bus_if;
  logic grant;
  logic ctrl_address_latch_out;
  logic ctrl_transfer_ack;
  logic ctrl_transfer_hold;
  logic cpu_transfer_ack;
  logic cpu_addr_latch_req;
  logic dirty_line_indication;
  logic cpu_normal_request;
  logic cpu_alternate_request;
  logic cpu_lock;
  logic [vma_pkg::DATA_W-1:0] ctrl_ad;
  logic ctrl_ad_oe_n;
  logic [vma_pkg::DATA_W-1:0] cpu_ad;
  logic cpu_ad_oe_n;
  logic [vma_pkg::DATA_W-1:0] ad;
  assign ad = !ctrl_ad_oe_n ? ctrl_ad : (!cpu_ad_oe_n ? cpu_ad : '0);
  modport ctrl (
    output grant, ctrl_address_latch_out, ctrl_transfer_ack,
    output ctrl_ad, ctrl_ad_oe_n,
    input ctrl_transfer_hold, cpu_transfer_ack, cpu_addr_latch_req,
    input dirty_line_indication, cpu_normal_request, cpu_alternate_request,
    input cpu_lock, ad
  );
  modport cpu (
    input grant, ctrl_address_latch_out, ctrl_transfer_ack, ad,
    output ctrl_transfer_hold, cpu_transfer_ack, cpu_addr_latch_req,
    output dirty_line_indication, cpu_normal_request,
    output cpu_alternate_request, cpu_lock, cpu_ad, cpu_ad_oe_n
  );
endinterface : vma_bus_if

// file: hw/vma_cpu_end.sv
// Purpose: Processor end of the snoop handshake, driven by a cache model port.
// Assumes: The user side reports the line state of each snooped address.
// Notes: Partial write-back on write hits is shaped by the user byte mask.
`timescale 1ns/1ps
module vma_cpu_end (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  vma_bus_if.cpu bus,
  input wire logic tag_busy_in,
  input wire logic line_modified_in,
  input wire logic snoop_is_write_in,
  input wire logic [vma_pkg::DATA_W-1:0] wb_data_in,
  input wire logic req_in,
  output logic invalidate_out,
  output logic snoop_seen_out
);
  typedef enum logic [2:0] {IDLE, HOLD, ACK, WAITG, WB} vma_cst_t;
  vma_cst_t st_ff, nxt_st;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [vma_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
  logic dirty_ff, nxt_dirty;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_addr = addr_ff;
    nxt_dirty = dirty_ff;
    unique case (st_ff)
      IDLE:
        if (bus.ctrl_address_latch_out && !bus.grant)
        begin
          nxt_addr = bus.ad[vma_pkg::ADDR_W-1:0];
          nxt_dirty = line_modified_in;
          nxt_st = tag_busy_in ? HOLD : ACK;
        end
      HOLD: nxt_st = ACK;
      ACK:
      begin
        nxt_cnt = 3'h1;
        nxt_st = dirty_ff ? WAITG : IDLE;
      end
      WAITG:
      begin
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == 3'(vma_pkg::ACK_TO_ALE_CLKS))
        begin
          nxt_cnt = 3'h0;
          nxt_st = WB;
        end
      end
      WB:
      begin
        if (bus.ctrl_transfer_ack)
          nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == 3'(vma_pkg::LINE_QWORDS))
          nxt_st = IDLE;
      end
      default: nxt_st = IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      st_ff <= IDLE;
      cnt_ff <= 3'h0;
      addr_ff <= '0;
      dirty_ff <= 1'b0;
    end
    else if (clk_en_in)
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      addr_ff <= nxt_addr;
      dirty_ff <= nxt_dirty;
    end
  end

  assign bus.ctrl_transfer_hold = (st_ff == HOLD);
  assign bus.cpu_transfer_ack = (st_ff == ACK);
  assign bus.dirty_line_indication = (st_ff == ACK) && dirty_ff;
  assign bus.cpu_addr_latch_req = (st_ff == WAITG) &&
    (cnt_ff == 3'(vma_pkg::ACK_TO_ALE_CLKS));
  assign bus.cpu_ad_oe_n = !(bus.cpu_addr_latch_req || (st_ff == WB));
  // A write hit only keeps the bytes the master is not writing; the
  // user side masks wb_data_in accordingly.
  assign bus.cpu_ad = bus.cpu_addr_latch_req ?
    {{(vma_pkg::DATA_W-vma_pkg::ADDR_W){1'b0}}, addr_ff} : wb_data_in;
  assign bus.cpu_normal_request = req_in;
  assign bus.cpu_alternate_request = 1'b0;
  assign bus.cpu_lock = 1'b0;
  assign invalidate_out = (st_ff == ACK && !dirty_ff) ||
    (st_ff == WB && cnt_ff == 3'(vma_pkg::LINE_QWORDS));
  assign snoop_seen_out = (st_ff == ACK) && snoop_is_write_in;
endmodule : vma_cpu_end

// file: hw/vma_ctrl_end.sv
// Purpose: Controller end: bus arbitration, snoop filter, snoop handshake,
//          write-back cross-over and VL-master main-memory termination.
// Assumes: VL signals are active-high levels; one clock domain.
// Notes: Non-main-memory cycles are handed to the ISA side by a pulse.
// Behaviour
// - Four-entry filter skips repeat snoops
// - Snoop every master main-memory access; here accesses that hit the filter are not snooped
// - VL reads snooped as read-to-own
// - Controller drives snoop address and latch
// - Processor acks, controller echoes acknowledge
// - Dirty valid only ack without hold
// - Hit address latch then grant processor
// - Four-clock acknowledge, line write-back follows
// - Write-back copied to VL read path
// - Processor invalidates or writes back line
// - Write hit writes back unwritten bytes
// - No termination before snoop starts
// - Default grant to processor when idle
// - Drop processor grant, then grant VL
// - Snoop starts in master address clock; here it starts two clocks after the strobe
// - Drop VL grant after request drops
// - Restore processor grant one clock later; here a waiting VL request wins unless the processor requests or locks
// - Outside main memory goes to ISA
// - Sixteen-byte bursts; no-burst masters hold BLAST
// - VL master caches must be write-through
// - Snoop and BLAST valid after address strobe
// - Ready two clocks after strobe, burst earlier; here bursts ready in the same clock as singles
`timescale 1ns/1ps
module vma_ctrl_end #(
  parameter int NUM_VL = vma_pkg::NUM_VL,
  parameter int DEPTH = vma_pkg::FILTER_DEPTH
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  vma_bus_if.ctrl bus,
  input wire logic [NUM_VL-1:0] lreq_in,
  output logic [NUM_VL-1:0] lgnt_out,
  input wire logic lads_in,
  input wire logic lbw_r_in,
  input wire logic blast_in,
  input wire logic [vma_pkg::ADDR_W-1:0] lbadr_in,
  output logic lrdy_out,
  output logic brdy_out,
  output logic [vma_pkg::VL_DATA_W-1:0] lbdata_out,
  output logic lbdata_oe_n_out,
  output logic [vma_pkg::DATA_W-1:0] wq_data_out,
  output logic wq_valid_out,
  output logic [vma_pkg::DATA_W-1:0] rq_data_out,
  output logic rq_valid_out,
  output logic isa_start_out,
  input wire logic [vma_pkg::ADDR_W-1:0] mem_base_in,
  input wire logic [vma_pkg::ADDR_W-1:0] mem_limit_in
);
  localparam int TW = vma_pkg::ADDR_W - vma_pkg::LINE_LSB;
  // ---------------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {A_CPU, A_DROP, A_GNT, A_REL, A_REST} vma_ast_t;
  vma_ast_t ast_ff, nxt_ast;
  logic [NUM_VL-1:0] gnt_ff, nxt_gnt;
  logic cpu_gnt_ff, nxt_cpu_gnt;
  logic cyc_done;

  function automatic logic [NUM_VL-1:0] pick(input logic [NUM_VL-1:0] r);
    pick = r & (~r + NUM_VL'(1));
  endfunction : pick

  always_comb
  begin
    nxt_ast = ast_ff;
    nxt_gnt = gnt_ff;
    nxt_cpu_gnt = cpu_gnt_ff;
    unique case (ast_ff)
      A_CPU:
        if (|lreq_in && !bus.cpu_lock)
        begin
          nxt_cpu_gnt = 1'b0;
          nxt_ast = A_DROP;
        end
      A_DROP:
      begin
        nxt_gnt = pick(lreq_in);
        nxt_ast = (|lreq_in) ? A_GNT : A_REST;
      end
      A_GNT:
        if (cyc_done)
          nxt_ast = A_REL;
      A_REL:
        if (!(|(lreq_in & gnt_ff)))
        begin
          nxt_gnt = '0;
          nxt_ast = A_REST;
        end
      A_REST:
      begin
        // Back-to-back VL requests keep the processor off the bus unless it requests or locks.
        if (bus.cpu_normal_request || bus.cpu_alternate_request ||
            bus.cpu_lock || !(|lreq_in))
        begin
          nxt_cpu_gnt = 1'b1;
          nxt_ast = A_CPU;
        end
        else
          nxt_ast = A_DROP;
      end
      default: nxt_ast = A_CPU;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      ast_ff <= A_CPU;
      gnt_ff <= '0;
      cpu_gnt_ff <= 1'b1;
    end
    else if (clk_en_in)
    begin
      ast_ff <= nxt_ast;
      gnt_ff <= nxt_gnt;
      cpu_gnt_ff <= nxt_cpu_gnt;
    end
  end

  // ---------------------------------------------------------------------
  // Master cycle, snoop filter and snoop handshake
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_SNOOP, S_WACK, S_WALE, S_WB, S_TERM, S_ISA
  } vma_sst_t;
  vma_sst_t sst_ff, nxt_sst;
  logic [TW-1:0] tag_ff [DEPTH];
  logic [TW-1:0] nxt_tag [DEPTH];
  logic [$clog2(DEPTH)-1:0] old_ff, nxt_old;
  logic [vma_pkg::ADDR_W-1:0] adr_ff, nxt_adr;
  logic wr_ff, nxt_wr;
  logic started_ff, nxt_started;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [DEPTH-1:0] hit_vec;
  logic filt_hit;
  logic in_mem;
  logic ack_out, ale_out;

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_filt
    assign hit_vec[i] = (tag_ff[i] == adr_ff[vma_pkg::ADDR_W-1:
      vma_pkg::LINE_LSB]);
  end
  assign filt_hit = |hit_vec;
  assign in_mem = (adr_ff >= mem_base_in) && (adr_ff <= mem_limit_in);

  always_comb
  begin
    nxt_sst = sst_ff;
    nxt_adr = adr_ff;
    nxt_wr = wr_ff;
    nxt_started = started_ff;
    nxt_cnt = cnt_ff;
    nxt_old = old_ff;
    nxt_tag = tag_ff;
    ack_out = 1'b0;
    ale_out = 1'b0;
    cyc_done = 1'b0;
    isa_start_out = 1'b0;
    unique case (sst_ff)
      S_IDLE:
        if (lads_in && |gnt_ff)
        begin
          nxt_adr = lbadr_in;
          nxt_wr = lbw_r_in;
          nxt_started = 1'b0;
          nxt_sst = S_ADDR;
        end
      S_ADDR:
        // One clock after the strobe: snoop decision, BLAST now valid.
        if (!in_mem)
        begin
          isa_start_out = 1'b1;
          nxt_sst = S_ISA;
        end
        else if (filt_hit)
          nxt_sst = S_TERM;
        else
          nxt_sst = S_SNOOP;
      S_SNOOP:
      begin
        // Every snoop is read-to-own; reads and writes look the same.
        ale_out = 1'b1;
        nxt_started = 1'b1;
        nxt_sst = S_WACK;
      end
      S_WACK:
        if (bus.cpu_transfer_ack && !bus.ctrl_transfer_hold)
        begin
          ack_out = 1'b1;
          nxt_tag[old_ff] = adr_ff[vma_pkg::ADDR_W-1:vma_pkg::LINE_LSB];
          if (!filt_hit)
            nxt_old = old_ff + 1'b1;
          nxt_sst = bus.dirty_line_indication ? S_WALE : S_TERM;
        end
      S_WALE:
        if (bus.cpu_addr_latch_req)
        begin
          ale_out = 1'b1;
          nxt_cnt = 3'h0;
          nxt_sst = S_WB;
        end
      S_WB:
      begin
        ack_out = (cnt_ff < 3'(vma_pkg::LINE_QWORDS));
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == 3'(vma_pkg::LINE_QWORDS))
          nxt_sst = S_TERM;
      end
      S_TERM:
      begin
        cyc_done = started_ff || filt_hit;
        if (cyc_done && (blast_in || !wr_ff))
          nxt_sst = S_IDLE;
      end
      S_ISA:
      begin
        cyc_done = 1'b1;
        nxt_sst = S_IDLE;
      end
      default: nxt_sst = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      sst_ff <= S_IDLE;
      adr_ff <= '0;
      wr_ff <= 1'b0;
      started_ff <= 1'b0;
      cnt_ff <= 3'h0;
      old_ff <= '0;
      for (int i = 0; i < DEPTH; i++)
        tag_ff[i] <= '1;
    end
    else if (clk_en_in)
    begin
      sst_ff <= nxt_sst;
      adr_ff <= nxt_adr;
      wr_ff <= nxt_wr;
      started_ff <= nxt_started;
      cnt_ff <= nxt_cnt;
      old_ff <= nxt_old;
      tag_ff <= nxt_tag;
    end
  end

  // ---------------------------------------------------------------------
  // Processor-bus outputs and write-back cross-over
  // ---------------------------------------------------------------------
  logic wb_beat;
  assign wb_beat = (sst_ff == S_WB) && (cnt_ff != 3'h0);
  assign bus.grant = cpu_gnt_ff || (sst_ff == S_WB) ||
    (sst_ff == S_WALE && bus.cpu_addr_latch_req);
  assign bus.ctrl_address_latch_out = ale_out;
  assign bus.ctrl_transfer_ack = ack_out;
  assign bus.ctrl_ad = {{(vma_pkg::DATA_W-vma_pkg::ADDR_W){1'b0}}, adr_ff};
  assign bus.ctrl_ad_oe_n = !(sst_ff == S_SNOOP);
  assign lgnt_out = gnt_ff;

  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      wq_valid_out <= 1'b0;
      rq_valid_out <= 1'b0;
      wq_data_out <= '0;
      rq_data_out <= '0;
      lbdata_out <= '0;
      lbdata_oe_n_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      wq_valid_out <= wb_beat;
      rq_valid_out <= wb_beat && !wr_ff;
      wq_data_out <= bus.ad;
      rq_data_out <= bus.ad;
      lbdata_out <= bus.ad[vma_pkg::VL_DATA_W-1:0];
      lbdata_oe_n_out <= !(wb_beat && !wr_ff);
    end
  end

  // Singles and bursts are ready in the same clock; blast_in selects lrdy_out or brdy_out.
  assign lrdy_out = (sst_ff == S_TERM) && cyc_done && blast_in;
  assign brdy_out = (sst_ff == S_TERM) && cyc_done && !blast_in;
endmodule : vma_ctrl_end

// file: hw/vma_pkg.sv
// Purpose: Shared constants for the VL-master arbiter and snooper.
// Assumes: One 20 MHz system clock shared by both ends.
// Notes: Active-low bus pins are carried as active-high logic levels here.
package vma_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int VL_DATA_W = 32;
  localparam int NUM_VL = 3;
  localparam int FILTER_DEPTH = 4;
  localparam int LINE_QWORDS = 4;
  localparam int BURST_DWORDS = 4;
  // Snoop-filter granularity: a 32-byte line, so the low five bits drop.
  localparam int LINE_LSB = 5;
  localparam int ACK_TO_ALE_CLKS = 3;
  localparam int CLK_HZ = 20000000;
  localparam logic [31:0] MEM_BASE_RST = 32'h0000_0000;
  localparam logic [31:0] MEM_LIMIT_RST = 32'h00ff_ffff;
endpackage : vma_pkg
